// ---- byte_store.sv ----
// Four-byte input buffer store with registered read data
`timescale 1ns/1ps
module byte_store (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Write port
   input wire logic we,
   input wire logic [1:0] waddr,
   input wire logic [7:0] wdata,
   // Read port
   input wire logic [1:0] raddr,
   output logic [7:0] rdata
);
   pport_pkg::store_state_t st_q;
   pport_pkg::store_state_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.rdata = st_q.mem[raddr];
      if (we) begin
         st_d.mem[waddr] = wdata;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata = st_q.rdata;
endmodule

// ---- pport_ext_model.sv ----
// Behavioural external processor on the slave pins
`timescale 1ns/1ps
module pport_ext_model (
   // Clock
   input wire logic clock,
   // Pins towards the unit
   output pport_pkg::ext_pins_t pins,
   input wire logic [7:0] ext_data_out,
   input wire logic ext_data_oe
);
   logic [7:0] last_q;

   initial begin
      pins = '0;
      last_q = 8'h00;
   end

   // Write strobes held 4 cycles, read strobes 6, idle 6; released bus shows inverse of last byte
   task automatic ext_write(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      pins.addr <= a;
      pins.data <= d;
      pins.cs <= 1'b1;
      pins.wr <= 1'b1;
      last_q = d;
      repeat (4) @(posedge clock);
      pins.cs <= 1'b0;
      pins.wr <= 1'b0;
      pins.data <= ~d;
      repeat (6) @(posedge clock);
   endtask

   task automatic ext_read(input logic [1:0] a, output logic [7:0] d, output logic oe);
      @(posedge clock);
      pins.addr <= a;
      pins.data <= ~last_q;
      pins.cs <= 1'b1;
      pins.rd <= 1'b1;
      repeat (6) @(posedge clock);
      d = ext_data_out;
      oe = ext_data_oe;
      pins.cs <= 1'b0;
      pins.rd <= 1'b0;
      repeat (6) @(posedge clock);
   endtask
endmodule

// ---- pport_map.svh ----
// Register offsets, field positions and reset values of the parallel port unit
// Behaviour
// - Chip-select pin enable set routes chip select to its pin, else port I/O.
// - Address pin enables 7..2 each make their pin an address line when set.
// - Pin enables 1..0 give pins to address 1/0 or latch strobes when set.
// - All-inputs-full reads 1 only while every input byte is full.
// - External write to a full input byte sets sticky overflow; software writes zero.
// - Each input byte has a full flag; software reading that byte clears it.
// - All-outputs-empty reads 1 only when every output byte is empty; resets 1.
// - External read of an empty output byte sets sticky underflow; software clears.
// - Output empty flags reset 1, clear on software write in slave modes, set on transmit.
// - Unused status, pin-enable and high-address positions read as zero.
// - Eight data bytes form four high/low pairs for 16-bit access.
// - Input pair A takes slave input; in master modes carries both directions.
// - Input pair B only buffers input in buffered slave modes; the code also writes it in mode 01 at pin address 2/3.
// - Master address pair and output pair A share one physical register pair.
// - Output pair B holds outgoing bytes only in buffered slave modes; the code also sends it in mode 01 at pin address 2/3.
// - Chip-select field 10 makes high-address bit 6 chip select, else address 14.
// - High-address bits 5..0 hold address 13..8; register resets to zero.
// - Chip-select field 10 enables chip select with 14 address bits; 00 disables.
// - Port mode 00 legacy, 01 addressable slave, 10 master 2, 11 master 1.
// - External write strobe depositing data sets that byte's full flag.
`ifndef PPORT_MAP_SVH
`define PPORT_MAP_SVH

// ==========================================
// Register offsets
`define PP_OUT_STAT_OFS 12'hf54
`define PP_IN_STAT_OFS 12'hf55
`define PP_PIN_EN_LO_OFS 12'hf56
`define PP_PIN_EN_HI_OFS 12'hf57
`define PP_MODE_OFS 12'hf5d
`define PP_CTRL_OFS 12'hf5e
`define PP_IN_A_LO_OFS 12'hf60
`define PP_IN_A_HI_OFS 12'hf61
`define PP_IN_B_LO_OFS 12'hf62
`define PP_IN_B_HI_OFS 12'hf63
`define PP_OUT_B_LO_OFS 12'hf64
`define PP_OUT_B_HI_OFS 12'hf65
`define PP_OUT_A_LO_OFS 12'hf6e
`define PP_OUT_A_HI_OFS 12'hf6f

// ==========================================
// Field positions
`define PP_SUM_BIT 7
`define PP_ERR_BIT 6
`define PP_CS_PIN_BIT 6
`define PP_CS_CTL_BIT 6
`define PP_INCM_LSB 3
`define PP_CSF_LSB 6
`define PP_HI_ADDR_MASK 8'h7f

// ==========================================
// Reset values and codes
`define PP_EMPTY_RESET 4'hf
`define PP_INCM_BUFFERED 2'h3
`define PP_CSF_ENABLED 2'h2

`endif

// ---- pport_pkg.sv ----
// Types shared by the parallel port unit
package pport_pkg;

   typedef enum logic [1:0] {
      MODE_LEGACY = 2'h0,
      MODE_ADDRESSED = 2'h1,
      MODE_MASTER2 = 2'h2,
      MODE_MASTER1 = 2'h3
   } port_mode_t;

   typedef struct packed {
      logic cs;
      logic rd;
      logic wr;
      logic [1:0] addr;
      logic [7:0] data;
   } ext_pins_t;

   typedef struct packed {
      logic [3:0][7:0] mem;
      logic [7:0] rdata;
   } store_state_t;

   typedef struct packed {
      ext_pins_t sync1;
      ext_pins_t sync2;
      logic wr_act;
      logic rd_act;
      logic [1:0] lat_addr;
      logic [7:0] lat_data;
      logic [1:0] in_ptr;
      logic [1:0] out_ptr;
      logic [3:0] in_full;
      logic in_ovf;
      logic [3:0] out_empty;
      logic out_unf;
      logic [3:0][7:0] out_bytes;
      logic [7:0] pin_en_lo;
      logic pin_en_cs;
      port_mode_t mode;
      logic [1:0] incm;
      logic [1:0] chip_select_function_field;
      logic [7:0] rdata;
      logic sel_store;
      logic [7:0] ext_data;
      logic ext_oe;
      logic [15:0] addr_out;
      logic cs_out;
      logic all_full;
      logic all_empty;
   } unit_state_t;

endpackage

// ---- pport_unit.sv ----
// Parallel port pin enables, buffer status, data pairs and high address
`timescale 1ns/1ps
`include "pport_map.svh"
module pport_unit (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // External processor pins
   input wire pport_pkg::ext_pins_t ext_in,
   output logic [7:0] ext_data_out,
   output logic ext_data_oe,
   // Pin function and master address
   output logic [7:0] address_pin_en,
   output logic chip_select_pin_en,
   output logic [15:0] port_address_lines,
   output logic chip_select_out,
   // Buffer summaries
   output logic all_inputs_full,
   output logic all_outputs_empty
);
   pport_pkg::unit_state_t st_q;
   pport_pkg::unit_state_t st_d;
   pport_pkg::ext_pins_t cur;
   logic master;
   logic slave;
   logic buffered;
   logic act_wr;
   logic act_rd;
   logic wr_evt;
   logic rd_evt;
   logic [1:0] widx;
   logic [1:0] ridx;
   logic [3:0] in_set;
   logic [3:0] in_clr;
   logic [3:0] out_set;
   logic [3:0] out_clr;
   logic ovf_set;
   logic unf_set;
   logic mem_we;
   logic [1:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic [1:0] mem_raddr;
   logic [7:0] mem_rdata;
   logic sw_in_rd;
   logic [7:0] rd_val;

   // ==========================================
   // Buffer index chosen by mode
   function automatic logic [1:0] pick_index(input logic addressed, input logic buf_mode,
                                             input logic [1:0] pin_addr, input logic [1:0] ptr);
      logic [1:0] r;
      r = 2'h0;
      if (addressed) begin
         r = pin_addr;
      end else if (buf_mode) begin
         r = ptr;
      end
      return r;
   endfunction

   // ==========================================
   // Input byte store
   byte_store u_store (
      .clock(clock),
      .rst(rst),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // ==========================================
   // Next state
   always_comb begin
      st_d = st_q;
      cur = st_q.sync2;
      master = st_q.mode[1];
      slave = ~master;
      buffered = (st_q.mode == pport_pkg::MODE_LEGACY) && (st_q.incm == `PP_INCM_BUFFERED);
      in_set = 4'h0;
      in_clr = 4'h0;
      out_set = 4'h0;
      out_clr = 4'h0;
      ovf_set = 1'b0;
      unf_set = 1'b0;
      mem_we = 1'b0;
      mem_waddr = 2'h0;
      mem_wdata = 8'h00;
      mem_raddr = 2'h0;
      sw_in_rd = 1'b0;
      rd_val = 8'h00;

      // Pin synchronisers
      st_d.sync1 = ext_in;
      st_d.sync2 = st_q.sync1;

      // External strobes, slave modes only
      act_wr = slave & cur.cs & cur.wr;
      act_rd = slave & cur.cs & cur.rd;
      st_d.wr_act = act_wr;
      st_d.rd_act = act_rd;
      if (act_wr) begin
         st_d.lat_data = cur.data;
         st_d.lat_addr = cur.addr;
      end
      wr_evt = st_q.wr_act & ~act_wr;
      rd_evt = act_rd & ~st_q.rd_act;
      widx = pick_index(st_q.mode == pport_pkg::MODE_ADDRESSED, buffered,
                        st_q.lat_addr, st_q.in_ptr);
      ridx = pick_index(st_q.mode == pport_pkg::MODE_ADDRESSED, buffered,
                        cur.addr, st_q.out_ptr);

      // External write ends: byte lands in the input store
      if (wr_evt) begin
         mem_we = 1'b1;
         mem_waddr = widx;
         mem_wdata = st_q.lat_data;
         in_set[widx] = 1'b1;
         ovf_set = st_q.in_full[widx];
         if (buffered) begin
            st_d.in_ptr = st_q.in_ptr + 2'h1;
         end
      end

      // External read starts: byte goes onto the data pins
      if (rd_evt) begin
         st_d.ext_data = st_q.out_bytes[ridx];
         out_set[ridx] = 1'b1;
         unf_set = st_q.out_empty[ridx];
         if (buffered) begin
            st_d.out_ptr = st_q.out_ptr + 2'h1;
         end
      end
      st_d.ext_oe = act_rd;

      // Software writes
      if (reg_wr) begin
         case (reg_addr)
            `PP_OUT_STAT_OFS: begin
               if (!reg_wdata[`PP_ERR_BIT]) begin
                  st_d.out_unf = 1'b0;
               end
            end
            `PP_IN_STAT_OFS: begin
               if (!reg_wdata[`PP_ERR_BIT]) begin
                  st_d.in_ovf = 1'b0;
               end
            end
            `PP_PIN_EN_LO_OFS: begin
               st_d.pin_en_lo = reg_wdata;
            end
            `PP_PIN_EN_HI_OFS: begin
               st_d.pin_en_cs = reg_wdata[`PP_CS_PIN_BIT];
            end
            `PP_MODE_OFS: begin
               st_d.mode = pport_pkg::port_mode_t'(reg_wdata[1:0]);
               st_d.incm = reg_wdata[`PP_INCM_LSB +: 2];
            end
            `PP_CTRL_OFS: begin
               st_d.chip_select_function_field = reg_wdata[`PP_CSF_LSB +: 2];
            end
            `PP_IN_A_LO_OFS, `PP_IN_A_HI_OFS: begin
               // Master modes send outgoing data through input pair A
               if (master && !wr_evt) begin
                  mem_we = 1'b1;
                  mem_waddr = {1'b0, reg_addr[0]};
                  mem_wdata = reg_wdata;
               end
            end
            `PP_OUT_A_LO_OFS: begin
               st_d.out_bytes[0] = reg_wdata;
               out_clr[0] = slave;
            end
            `PP_OUT_A_HI_OFS: begin
               st_d.out_bytes[1] = reg_wdata;
               out_clr[1] = slave;
            end
            `PP_OUT_B_LO_OFS: begin
               st_d.out_bytes[2] = reg_wdata;
               out_clr[2] = slave;
            end
            `PP_OUT_B_HI_OFS: begin
               st_d.out_bytes[3] = reg_wdata;
               out_clr[3] = slave;
            end
            default: begin
            end
         endcase
      end

      // Software reads
      if (reg_rd) begin
         case (reg_addr)
            `PP_OUT_STAT_OFS: begin
               rd_val = {&st_q.out_empty, st_q.out_unf, 2'h0, st_q.out_empty};
            end
            `PP_IN_STAT_OFS: begin
               rd_val = {&st_q.in_full, st_q.in_ovf, 2'h0, st_q.in_full};
            end
            `PP_PIN_EN_LO_OFS: begin
               rd_val = st_q.pin_en_lo;
            end
            `PP_PIN_EN_HI_OFS: begin
               rd_val = {1'b0, st_q.pin_en_cs, 6'h00};
            end
            `PP_MODE_OFS: begin
               rd_val = {3'h0, st_q.incm, 1'b0, st_q.mode};
            end
            `PP_CTRL_OFS: begin
               rd_val = {st_q.chip_select_function_field, 6'h00};
            end
            `PP_IN_A_LO_OFS, `PP_IN_A_HI_OFS, `PP_IN_B_LO_OFS, `PP_IN_B_HI_OFS: begin
               sw_in_rd = 1'b1;
               mem_raddr = reg_addr[1:0];
               in_clr[reg_addr[1:0]] = 1'b1;
            end
            `PP_OUT_A_LO_OFS: begin
               rd_val = st_q.out_bytes[0];
            end
            `PP_OUT_A_HI_OFS: begin
               if (master) begin
                  rd_val = st_q.out_bytes[1] & `PP_HI_ADDR_MASK;
               end else begin
                  rd_val = st_q.out_bytes[1];
               end
            end
            `PP_OUT_B_LO_OFS: begin
               rd_val = st_q.out_bytes[2];
            end
            `PP_OUT_B_HI_OFS: begin
               rd_val = st_q.out_bytes[3];
            end
            default: begin
               rd_val = 8'h00;
            end
         endcase
      end
      st_d.rdata = rd_val;
      st_d.sel_store = sw_in_rd;

      // Flag updates: in the same cycle a hardware set wins for full flags, a software clear wins for empty flags
      st_d.in_full = (st_q.in_full & ~in_clr) | in_set;
      st_d.out_empty = (st_q.out_empty | out_set) & ~out_clr;
      if (ovf_set) begin
         st_d.in_ovf = 1'b1;
      end
      if (unf_set) begin
         st_d.out_unf = 1'b1;
      end
      st_d.all_full = &st_d.in_full;
      st_d.all_empty = &st_d.out_empty;

      // Master address and chip select
      st_d.addr_out = 16'h0000;
      st_d.cs_out = 1'b0;
      if (master) begin
         st_d.addr_out[7:0] = st_q.out_bytes[0];
         st_d.addr_out[13:8] = st_q.out_bytes[1][5:0];
         if (st_q.chip_select_function_field == `PP_CSF_ENABLED) begin
            st_d.cs_out = st_q.out_bytes[1][`PP_CS_CTL_BIT];
         end else begin
            st_d.addr_out[14] = st_q.out_bytes[1][`PP_CS_CTL_BIT];
         end
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q <= '0;
         st_q.out_empty <= `PP_EMPTY_RESET;
         st_q.all_empty <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================
   // Outputs
   assign reg_rdata = st_q.sel_store ? mem_rdata : st_q.rdata;
   assign ext_data_out = st_q.ext_data;
   assign ext_data_oe = st_q.ext_oe;
   assign address_pin_en = st_q.pin_en_lo;
   assign chip_select_pin_en = st_q.pin_en_cs;
   assign port_address_lines = st_q.addr_out;
   assign chip_select_out = st_q.cs_out;
   assign all_inputs_full = st_q.all_full;
   assign all_outputs_empty = st_q.all_empty;
endmodule

// ---- pport_unit_properties.sv ----
// Concurrent checks on the parallel port unit ports
`timescale 1ns/1ps
`include "pport_map.svh"
module pport_unit_properties (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Pin function and master address
   input wire logic [7:0] address_pin_en,
   input wire logic chip_select_pin_en,
   input wire logic [15:0] port_address_lines,
   input wire logic chip_select_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // ==========================================
   // Register side
   a_pin_en_write: assert property (
      reg_wr && reg_addr == `PP_PIN_EN_LO_OFS |=> address_pin_en == $past(reg_wdata))
      else $error("pin enable low not taken");
   a_cs_pin_write: assert property (
      reg_wr && reg_addr == `PP_PIN_EN_HI_OFS |=> chip_select_pin_en == $past(reg_wdata[6]))
      else $error("chip select pin enable not taken");
   a_rdata_idle: assert property (
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_out_sum: assert property (
      reg_rd && reg_addr == `PP_OUT_STAT_OFS |=> reg_rdata[7] == (&reg_rdata[3:0]))
      else $error("output summary disagrees with byte flags");
   a_in_sum: assert property (
      reg_rd && reg_addr == `PP_IN_STAT_OFS |=> reg_rdata[7] == (&reg_rdata[3:0]))
      else $error("input summary disagrees with byte flags");
   a_status_gap: assert property (
      reg_rd && (reg_addr == `PP_OUT_STAT_OFS || reg_addr == `PP_IN_STAT_OFS)
      |=> reg_rdata[5:4] == 2'h0)
      else $error("status gap bits not zero");
   a_pin_hi_zero: assert property (
      reg_rd && reg_addr == `PP_PIN_EN_HI_OFS |=> (reg_rdata & 8'hbf) == 8'h00)
      else $error("pin enable high unused bits not zero");

   // ==========================================
   // Master address
   a_cs_not_addr: assert property (
      chip_select_out |-> !port_address_lines[14])
      else $error("address 14 driven while chip select in use");
   a_addr_top_zero: assert property (
      port_address_lines[15] == 1'b0)
      else $error("address 15 driven");
endmodule

// ---- pport_unit_tb.sv ----
// Self-checking bench for the parallel port unit
`timescale 1ns/1ps
`include "pport_map.svh"
module pport_unit_tb;
   logic clock, rst, reg_wr, reg_rd, chip_select_pin_en, chip_select_out;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, ext_data_out, address_pin_en, d;
   logic ext_data_oe, all_inputs_full, all_outputs_empty, oe;
   logic [15:0] port_address_lines;
   pport_pkg::ext_pins_t ext_pins;
   int num_errors = 0;
   int n_tests = 0;
   logic [7:0] ob [4] = '{8'h11, 8'h9c, 8'h33, 8'h44};
   logic [11:0] oofs [4] = '{`PP_OUT_A_LO_OFS, `PP_OUT_A_HI_OFS, `PP_OUT_B_LO_OFS,
      `PP_OUT_B_HI_OFS};
   logic [7:0] fl [4] = '{8'h01, 8'h03, 8'h07, 8'h8f};

   pport_unit u_pport_unit (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_in(ext_pins), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
      .address_pin_en(address_pin_en), .chip_select_pin_en(chip_select_pin_en),
      .port_address_lines(port_address_lines), .chip_select_out(chip_select_out),
      .all_inputs_full(all_inputs_full), .all_outputs_empty(all_outputs_empty));
   pport_ext_model u_pport_ext_model (.clock(clock), .pins(ext_pins),
      .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe));

   always #2.5 clock = ~clock;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      // Read data stand only in the cycle after the strobe
      @(negedge clock);
      chk(reg_rdata, e);
   endtask

   task automatic settle();
      repeat (2) @(posedge clock);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clock);
      num_errors++;
      stop_test();
   end

   initial begin
      clock = 1'b0;
      rst = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rd(`PP_OUT_STAT_OFS, 8'h8f);
      rd(`PP_IN_STAT_OFS, 8'h00);
      rd(`PP_PIN_EN_LO_OFS, 8'h00);
      rd(`PP_PIN_EN_HI_OFS, 8'h00);
      rd(`PP_OUT_A_HI_OFS, 8'h00);
      rd(12'h100, 8'h00);
      chk(all_outputs_empty, 1'b1);
      $display("test reset done");
      wr(`PP_PIN_EN_LO_OFS, 8'ha5);
      wr(`PP_PIN_EN_HI_OFS, 8'hff);
      wr(`PP_OUT_STAT_OFS, 8'hff);
      rd(`PP_PIN_EN_LO_OFS, 8'ha5);
      rd(`PP_PIN_EN_HI_OFS, 8'h40);
      rd(`PP_OUT_STAT_OFS, 8'h8f);
      chk(address_pin_en, 8'ha5);
      chk(chip_select_pin_en, 1'b1);
      $display("test pin enables done");
      wr(`PP_MODE_OFS, 8'h01);
      for (int i = 0; i < 4; i++) wr(oofs[i], ob[i]);
      rd(`PP_OUT_STAT_OFS, 8'h00);
      chk(all_outputs_empty, 1'b0);
      for (int i = 0; i < 4; i++) begin
         u_pport_ext_model.ext_read(2'(i), d, oe);
         chk(d, ob[i]);
         chk(oe, 1'b1);
         rd(`PP_OUT_STAT_OFS, fl[i]);
      end
      u_pport_ext_model.ext_read(2'h0, d, oe);
      rd(`PP_OUT_STAT_OFS, 8'hcf);
      wr(`PP_OUT_STAT_OFS, 8'h40);
      rd(`PP_OUT_STAT_OFS, 8'hcf);
      wr(`PP_OUT_STAT_OFS, 8'h00);
      rd(`PP_OUT_STAT_OFS, 8'h8f);
      $display("test output bytes done");
      for (int i = 0; i < 4; i++) begin
         u_pport_ext_model.ext_write(2'(i), 8'ha0 + 8'(i));
         rd(`PP_IN_STAT_OFS, fl[i]);
      end
      chk(all_inputs_full, 1'b1);
      u_pport_ext_model.ext_write(2'h2, 8'h5e);
      rd(`PP_IN_STAT_OFS, 8'hcf);
      rd(`PP_IN_A_LO_OFS, 8'ha0);
      rd(`PP_IN_STAT_OFS, 8'h4e);
      rd(`PP_IN_B_LO_OFS, 8'h5e);
      rd(`PP_IN_STAT_OFS, 8'h4a);
      wr(`PP_IN_STAT_OFS, 8'h00);
      rd(`PP_IN_STAT_OFS, 8'h0a);
      $display("test input bytes done");
      wr(`PP_MODE_OFS, 8'h02);
      wr(`PP_IN_A_LO_OFS, 8'h5a);
      rd(`PP_IN_A_LO_OFS, 8'h5a);
      u_pport_ext_model.ext_write(2'h0, 8'hee);
      rd(`PP_IN_STAT_OFS, 8'h0a);
      wr(`PP_CTRL_OFS, 8'h80);
      wr(`PP_OUT_A_LO_OFS, 8'h34);
      wr(`PP_OUT_A_HI_OFS, 8'h45);
      settle();
      chk(port_address_lines, 16'h0534);
      chk(chip_select_out, 1'b1);
      wr(`PP_CTRL_OFS, 8'h00);
      settle();
      chk(port_address_lines, 16'h4534);
      chk(chip_select_out, 1'b0);
      for (int m = 0; m < 4; m++) begin
         wr(`PP_MODE_OFS, 8'(m));
         settle();
         chk(port_address_lines, (m > 1) ? 16'h4534 : 16'h0000);
      end
      $display("test master address done");
      wr(`PP_MODE_OFS, 8'h18);
      rd(`PP_IN_A_HI_OFS, 8'ha1);
      rd(`PP_IN_B_HI_OFS, 8'ha3);
      u_pport_ext_model.ext_write(2'h3, 8'h61);
      u_pport_ext_model.ext_write(2'h3, 8'h62);
      rd(`PP_IN_STAT_OFS, 8'h03);
      rd(`PP_IN_A_LO_OFS, 8'h61);
      rd(`PP_IN_A_HI_OFS, 8'h62);
      wr(`PP_OUT_A_LO_OFS, 8'h71);
      wr(`PP_OUT_A_HI_OFS, 8'h72);
      rd(`PP_OUT_STAT_OFS, 8'h0c);
      u_pport_ext_model.ext_read(2'h3, d, oe);
      chk(d, 8'h71);
      u_pport_ext_model.ext_read(2'h3, d, oe);
      chk(d, 8'h72);
      rd(`PP_OUT_STAT_OFS, 8'h8f);
      $display("test buffered slave done");
      @(posedge clock);
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd(`PP_OUT_STAT_OFS, 8'h8f);
      rd(`PP_IN_STAT_OFS, 8'h00);
      rd(`PP_OUT_A_HI_OFS, 8'h00);
      chk(port_address_lines, 16'h0000);
      chk(address_pin_en, 8'h00);
      chk(chip_select_pin_en, 1'b0);
      chk(all_outputs_empty, 1'b1);
      $display("test mid-run reset done");
      stop_test();
   end
endmodule

bind pport_unit pport_unit_properties u_pport_unit_properties (.clock(clock), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .address_pin_en(address_pin_en),
   .chip_select_pin_en(chip_select_pin_en), .port_address_lines(port_address_lines),
   .chip_select_out(chip_select_out));
